// [bench/adc_timing_and_clock_select_bench.sv]
// Self-checking bench for the converter timing block
`timescale 1ns/1ps
module adc_timing_and_clock_select_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int HALF = 8;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic osc, strap, cpu_clk_o, busy_o, sampling_o, done_o;
  logic [11:0] ain;
  logic [9:0] result_o;
  logic pll_mode = 1'b0;
  logic [11:0] level = 12'h000;
  logic [15:0] rd_val;
  logic [11:0] lv [4] = '{12'h155, 12'hf80, 12'h500, 12'h2aa};
  logic [9:0] res [4] = '{10'h155, 10'h000, 10'h3ff, 10'h2aa};
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int s_len, t_len, edges, tcc, tsc;
  always #2 clock_i = ~clock_i;

  adc_timing adc_timing_i (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_i(osc),
    .clock_source_strap_i(strap), .cpu_clk_o(cpu_clk_o), .ain_i(ain), .busy_o(busy_o),
    .sampling_o(sampling_o), .done_o(done_o), .result_o(result_o));
  analog_osc_model #(.HALF(HALF)) analog_osc_model_i (.clock_i(clock_i),
    .pll_mode_i(pll_mode), .level_i(level), .sampling_i(sampling_o), .busy_i(busy_o),
    .osc_o(osc), .strap_o(strap), .ain_o(ain));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_cnt(input string name, input int exp, input int got, input int tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic do_reset(input logic mode);
    @(posedge clock_i);
    srst_i <= 1'b1;
    pll_mode <= mode;
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
  endtask

  // Edges seen over 20 oscillator half-periods
  task automatic count_edges(output int c);
    logic prev;
    c = 0;
    #1 prev = cpu_clk_o;
    repeat (20 * HALF)
    begin
      @(posedge clock_i);
      #1;
      if (cpu_clk_o !== prev)
        c++;
      prev = cpu_clk_o;
    end
  endtask

  // Status read and a refused restart are folded into the timed span
  task automatic run_conv(input logic [1:0] cc, input logic [1:0] sc, input logic [11:0] lvl);
    int n;
    level <= lvl;
    reg_write(adc_pkg::CTRL_ADDR, {cc, sc, 11'h000, 1'b1});
    n = 0;
    #1;
    while (sampling_o !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    reg_read(adc_pkg::STAT_ADDR, rd_val);
    check_val("status busy", {14'h0000, pll_mode, 1'b1}, rd_val);
    reg_write(adc_pkg::CTRL_ADDR, {cc, sc, 11'h000, 1'b1});
    #1;
    s_len = 4;
    t_len = 4;
    while (done_o !== 1'b1 && t_len < 40000)
    begin
      if (sampling_o === 1'b1)
        s_len++;
      t_len++;
      @(posedge clock_i);
      #1;
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      $display("[ERR] run time expected below %0d seen %0d", 60000, cycles);
      give_verdict;
    end
  end

  initial
  begin
    do_reset(1'b0);
    reg_read(adc_pkg::CTRL_ADDR, rd_val);
    check_val("ctrl reset", adc_pkg::CTRL_RESET, rd_val);
    reg_read(adc_pkg::STAT_ADDR, rd_val);
    check_val("status direct", 16'h0000, rd_val);
    reg_read(4'hc, rd_val);
    check_val("unmapped", 16'h0000, rd_val);
    reg_write(adc_pkg::CTRL_ADDR, 16'hb000);
    reg_read(adc_pkg::CTRL_ADDR, rd_val);
    check_val("ctrl fields", 16'hb000, rd_val);
    count_edges(edges);
    check_cnt("direct edges", 20, edges, 0);
    for (int i = 0; i < 4; i++)
    begin
      // Reserved code 01 is never programmed; pass 1 uses code 11
      tcc = (i == 2) ? 96 : (i == 0) ? 24 : 48;
      tsc = tcc << i;
      run_conv((i == 1) ? 2'b11 : i[1:0], i[1:0], lv[i]);
      check_cnt("sample span", 2 * tsc * HALF, s_len, 0);
      check_cnt("conversion", (2 * tsc + 14 * tcc + 4) * HALF, t_len, 1);
      @(posedge clock_i);
      #1;
      check_val("done width", 16'h0000, {14'h0000, done_o, busy_o});
      check_val("result port", {6'h00, res[i]}, {6'h00, result_o});
      reg_read(adc_pkg::RES_ADDR, rd_val);
      check_val("result", {6'h00, res[i]}, rd_val);
    end
    do_reset(1'b1);
    reg_read(adc_pkg::STAT_ADDR, rd_val);
    check_val("status loop", 16'h0002, rd_val);
    // Let the loop settle before timing it
    repeat (400) @(posedge clock_i);
    count_edges(edges);
    check_cnt("loop edges", 80, edges, 8);
    run_conv(2'b00, 2'b00, 12'h0aa);
    check_cnt("loop sample", 2 * 24 * HALF / 4, s_len, 12);
    check_cnt("loop conversion", (2 * 24 + 14 * 24 + 4) * HALF / 4, t_len, 8);
    reg_read(adc_pkg::RES_ADDR, rd_val);
    check_val("loop result", 16'h00aa, rd_val);
    give_verdict;
  end
endmodule

// [bench/analog_osc_model.sv]
// Far side model: oscillator, clock source strap and analog source
`timescale 1ns/1ps
module analog_osc_model
#(
  parameter int HALF = 8
)
(
  // Clock
  input wire logic clock_i,
  // Bench control
  input wire logic pll_mode_i,
  input wire logic [11:0] level_i,
  // Converter status
  input wire logic sampling_i,
  input wire logic busy_i,
  // Outputs
  output logic osc_o,
  output logic strap_o,
  output logic [11:0] ain_o
);
  int cnt = 0;
  logic moved = 1'b0;
  initial osc_o = 1'b0;
  // Strap held steady across the whole reset
  assign strap_o = pll_mode_i;
  // Input swings away after sampling so a late capture shows up
  assign ain_o = moved ? ~level_i : level_i;
  always @(posedge clock_i)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      osc_o <= ~osc_o;
    moved <= busy_i && (moved || $fell(sampling_i));
  end
endmodule

// [logic/adc_pkg.sv]
// Constants and types for the converter timing block
// Summary of operation
// - Conversion clock code: 24, reserved, 96, 48 half-periods
// - Sample clock is 1, 2, 4, 8 conversion clocks
// - Sample two sample clocks; total 14cc+sample+4
// - Input ignored once the sample phase ends
// - Sample, determine, then load result in time
// - Out-of-range input clamps to 000 or 3ff
// - Strap low at reset: direct oscillator drive
// - Direct drive: half-periods follow oscillator duty cycle
// - Strap high at reset: locked loop, times four
// - Loop realigns every fourth transition, gradually
// - Both cpu clock edges mark half-period ticks
package adc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [3:0] RES_ADDR = 4'h8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int CC_HI = 15;
  localparam int CC_LO = 14;
  localparam int SC_HI = 13;
  localparam int SC_LO = 12;
  localparam int START_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int PLL_BIT = 1;
  // ----------------------------------------
  // Timing in half-periods
  // ----------------------------------------
  localparam logic [10:0] TCC_CODE0 = 11'h018;
  localparam logic [10:0] TCC_CODE2 = 11'h060;
  localparam logic [10:0] TCC_CODE3 = 11'h030;
  localparam logic [10:0] CONV_TCC = 11'h00e;
  localparam logic [10:0] LOAD_TCL = 11'h004;
  localparam logic [10:0] SAMPLE_TSC = 11'h002;
  localparam logic [9:0] RES_MIN = 10'h000;
  localparam logic [9:0] RES_MAX = 10'h3ff;
  // ----------------------------------------
  // Clock generator
  // ----------------------------------------
  localparam logic [1:0] REALIGN_TRANS = 2'h3;
  localparam int SPAN_SHIFT = 4;
  localparam logic [7:0] STEP_INIT = 8'h08;
  localparam logic [7:0] STEP_MIN = 8'h01;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ARM = 6'h02,
    ST_SAMPLE = 6'h04,
    ST_CONV = 6'h08,
    ST_LOAD = 6'h10,
    ST_DONE = 6'h20
  } state_t;
endpackage

// [logic/adc_timing.sv]
// Converter sequencer, register port and clock source selection
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module adc_timing
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Clock source
  input wire logic osc_i,
  input wire logic clock_source_strap_i,
  output logic cpu_clk_o,
  // Analog side, signed input code
  input wire logic [11:0] ain_i,
  // Status
  output logic busy_o,
  output logic sampling_o,
  output logic done_o,
  output logic [9:0] result_o
);
  typedef struct packed {
    adc_pkg::state_t st;
    logic [15:0] ctrl;
    logic [1:0] csel;
    logic [1:0] ssel;
    logic [10:0] tcc;
    logic [10:0] cnt;
    logic [9:0] held;
    logic [9:0] result;
    logic pll;
    logic [15:0] rdata;
    logic [11:0] smp_ticks;
    logic [11:0] all_ticks;
  } core_t;

  core_t q;
  core_t d;
  logic tick;
  logic [10:0] tcc_sel;
  logic [10:0] sample_len;
  logic [10:0] conv_len;
  logic [9:0] clamped;
  logic start_req;

  // ----------------------------------------
  // Half-period source
  // ----------------------------------------
  half_period_gen half_period_gen_i
  (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .osc_i(osc_i),
    .pll_en_i(q.pll),
    .cpu_clk_o(cpu_clk_o),
    .tick_o(tick)
  );

  // ----------------------------------------
  // Timing decode
  // ----------------------------------------
  always_comb
  begin
    // Reserved code runs as the shortest setting
    case (q.csel)
      2'h2: tcc_sel = adc_pkg::TCC_CODE2;
      2'h3: tcc_sel = adc_pkg::TCC_CODE3;
      default: tcc_sel = adc_pkg::TCC_CODE0;
    endcase
  end

  // Two sample clocks, each tcc shifted by the sample code
  assign sample_len = 11'((q.tcc << q.ssel) * adc_pkg::SAMPLE_TSC);
  assign conv_len = 11'(q.tcc * adc_pkg::CONV_TCC);

  // Below ground reads as a negative code, above reference as bit 10
  always_comb
  begin
    if (ain_i[11])
    begin
      clamped = adc_pkg::RES_MIN;
    end
    else if (ain_i[10])
    begin
      clamped = adc_pkg::RES_MAX;
    end
    else
    begin
      clamped = ain_i[9:0];
    end
  end

  assign start_req = wr_i && (addr_i == adc_pkg::CTRL_ADDR) && wdata_i[adc_pkg::START_BIT];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.rdata = 16'h0000;
    if (wr_i && addr_i == adc_pkg::CTRL_ADDR)
    begin
      d.ctrl = wdata_i;
      d.ctrl[adc_pkg::START_BIT] = 1'b0;
    end
    if (rd_i)
    begin
      case (addr_i)
        adc_pkg::CTRL_ADDR: d.rdata = q.ctrl;
        adc_pkg::STAT_ADDR:
        begin
          d.rdata[adc_pkg::BUSY_BIT] = (q.st != adc_pkg::ST_IDLE);
          d.rdata[adc_pkg::PLL_BIT] = q.pll;
        end
        adc_pkg::RES_ADDR: d.rdata = {6'h00, q.result};
        default: d.rdata = 16'h0000;
      endcase
    end
    if (tick && (q.st == adc_pkg::ST_SAMPLE || q.st == adc_pkg::ST_CONV
        || q.st == adc_pkg::ST_LOAD))
    begin
      d.all_ticks = q.all_ticks + 12'h001;
    end
    case (q.st)
      adc_pkg::ST_IDLE:
      begin
        if (start_req)
        begin
          // Timing is frozen for the whole conversion
          d.csel = wdata_i[adc_pkg::CC_HI:adc_pkg::CC_LO];
          d.ssel = wdata_i[adc_pkg::SC_HI:adc_pkg::SC_LO];
          d.st = adc_pkg::ST_ARM;
        end
      end
      adc_pkg::ST_ARM:
      begin
        // Conversion starts on a half-period boundary
        d.tcc = tcc_sel;
        if (tick)
        begin
          d.st = adc_pkg::ST_SAMPLE;
          d.cnt = 11'h000;
          d.smp_ticks = 12'h000;
          d.all_ticks = 12'h000;
        end
      end
      adc_pkg::ST_SAMPLE:
      begin
        d.held = clamped;
        if (tick)
        begin
          d.smp_ticks = q.smp_ticks + 12'h001;
          d.cnt = q.cnt + 11'h001;
          if (q.cnt + 11'h001 == sample_len)
          begin
            d.st = adc_pkg::ST_CONV;
            d.cnt = 11'h000;
          end
        end
      end
      adc_pkg::ST_CONV:
      begin
        if (tick)
        begin
          d.cnt = q.cnt + 11'h001;
          if (q.cnt + 11'h001 == conv_len)
          begin
            d.st = adc_pkg::ST_LOAD;
            d.cnt = 11'h000;
          end
        end
      end
      adc_pkg::ST_LOAD:
      begin
        if (tick)
        begin
          d.cnt = q.cnt + 11'h001;
          if (q.cnt + 11'h001 == adc_pkg::LOAD_TCL)
          begin
            d.result = q.held;
            d.st = adc_pkg::ST_DONE;
          end
        end
      end
      adc_pkg::ST_DONE:
      begin
        d.st = adc_pkg::ST_IDLE;
      end
      default:
      begin
        d.st = adc_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      q <= '0;
      q.st <= adc_pkg::ST_IDLE;
      q.ctrl <= adc_pkg::CTRL_RESET;
      // Strap is followed for as long as reset is held
      q.pll <= clock_source_strap_i;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign busy_o = (q.st != adc_pkg::ST_IDLE);
  assign sampling_o = (q.st == adc_pkg::ST_SAMPLE);
  assign done_o = (q.st == adc_pkg::ST_DONE);
  assign result_o = q.result;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  chk_tcc_code: assert property (
    (q.st == adc_pkg::ST_SAMPLE) |->
      ((q.csel == 2'h2) ? (q.tcc == 11'h060) :
       (q.csel == 2'h3) ? (q.tcc == 11'h030) : (q.tcc == 11'h018)))
    else $error("conversion clock length wrong for code");
  chk_sample_len: assert property (
    (q.st == adc_pkg::ST_CONV && $past(q.st) == adc_pkg::ST_SAMPLE) |->
      (q.smp_ticks == 12'((q.tcc << q.ssel) << 1)))
    else $error("sample phase length wrong");
  chk_conv_total: assert property (
    done_o |-> (q.all_ticks == 12'((q.tcc << q.ssel) * 2 + q.tcc * 14 + 4)))
    else $error("conversion time wrong");
  chk_input_hold: assert property (
    (q.st == adc_pkg::ST_CONV || q.st == adc_pkg::ST_LOAD) |=> $stable(q.held))
    else $error("held sample changed after sample phase");
  chk_result_load: assert property (
    done_o |-> (result_o == q.held) && ($past(q.st) == adc_pkg::ST_LOAD))
    else $error("result not loaded from held sample");
  chk_clamp_low: assert property (
    (sampling_o && ain_i[11]) |=> (q.held == 10'h000))
    else $error("low input not clamped to zero");
  chk_clamp_high: assert property (
    (sampling_o && !ain_i[11] && ain_i[10]) |=> (q.held == 10'h3ff))
    else $error("high input not clamped to full scale");
  chk_strap_catch: assert property (
    $fell(srst_i) |-> (q.pll == $past(clock_source_strap_i)))
    else $error("clock source not taken from strap");
  chk_mode_stable: assert property (
    !$past(srst_i) |-> $stable(q.pll))
    else $error("clock source changed outside reset");
  chk_done_pulse: assert property (
    done_o |=> !done_o ##1 !done_o)
    else $error("completion pulse longer than one clock");

  // ----------------------------------------
  // Sequencer flow checks
  // ----------------------------------------
  // A refused restart must leave the running timing alone
  chk_start_arm: assert property (
    (q.st == adc_pkg::ST_IDLE && start_req) |=>
      (q.st == adc_pkg::ST_ARM))
    else $error("idle start not accepted");
  chk_busy_refuse: assert property (
    ((sampling_o || q.st == adc_pkg::ST_CONV || q.st == adc_pkg::ST_LOAD) && start_req) |=>
      (q.st != adc_pkg::ST_ARM))
    else $error("start accepted while converting");
  chk_arm_wait: assert property (
    (q.st == adc_pkg::ST_ARM && !tick) |=>
      (q.st == adc_pkg::ST_ARM))
    else $error("sampling began off a half-period boundary");
  chk_sample_entry: assert property (
    $rose(sampling_o) |->
      $past(tick))
    else $error("sample phase entered without a tick");
  chk_sample_bound: assert property (
    sampling_o |->
      (q.cnt < sample_len))
    else $error("sample phase overran its length");
  chk_conv_bound: assert property (
    (q.st == adc_pkg::ST_CONV) |->
      (q.cnt < conv_len))
    else $error("determination overran its length");
  chk_load_bound: assert property (
    (q.st == adc_pkg::ST_LOAD) |->
      (q.cnt < adc_pkg::LOAD_TCL))
    else $error("result load overran its length");
  chk_conv_entry: assert property (
    (q.st == adc_pkg::ST_LOAD && $past(q.st) == adc_pkg::ST_CONV) |->
      (q.all_ticks == 12'((q.tcc << q.ssel) * 2 + q.tcc * 14)))
    else $error("sample plus determination length wrong");
  chk_timing_frozen: assert property (
    (sampling_o || q.st == adc_pkg::ST_CONV || q.st == adc_pkg::ST_LOAD) |=>
      ($stable(q.tcc) && $stable(q.ssel)))
    else $error("timing selects moved during conversion");

  // ----------------------------------------
  // Sample and result checks
  // ----------------------------------------
  // Result only moves in the completion cycle
  chk_result_hold: assert property (
    !done_o |->
      $stable(result_o))
    else $error("result changed outside completion");
  chk_held_track: assert property (
    sampling_o |=>
      (q.held == $past(clamped)))
    else $error("held sample not tracking during sampling");
  chk_clamp_pass: assert property (
    (sampling_o && !ain_i[11] && !ain_i[10]) |=>
      (q.held == $past(ain_i[9:0])))
    else $error("in-range input not passed through");
  chk_done_tick: assert property (
    done_o |->
      $past(tick))
    else $error("completion not on a half-period tick");

  // ----------------------------------------
  // Register port checks
  // ----------------------------------------
  // Answers reflect the state of the cycle before
  chk_ctrl_store: assert property (
    ($past(wr_i) && $past(addr_i) == adc_pkg::CTRL_ADDR) |->
      (q.ctrl[adc_pkg::CC_HI:adc_pkg::SC_LO] == $past(wdata_i[adc_pkg::CC_HI:adc_pkg::SC_LO])
       && !q.ctrl[adc_pkg::START_BIT]))
    else $error("control fields not stored");
  chk_status_busy: assert property (
    ($past(rd_i) && $past(addr_i) == adc_pkg::STAT_ADDR) |->
      (rdata_o[adc_pkg::BUSY_BIT] == $past(busy_o)))
    else $error("status busy bit wrong");
endmodule

// [logic/half_period_gen.sv]
// Cpu clock and half-period tick generator
`timescale 1ns/1ps
module half_period_gen
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Oscillator and mode
  input wire logic osc_i,
  input wire logic pll_en_i,
  // Outputs
  output logic cpu_clk_o,
  output logic tick_o
);
  typedef struct packed {
    logic osc;
    logic [1:0] trans;
    logic [9:0] span;
    logic [7:0] step;
    logic [7:0] phase;
    logic cpu_clk;
    logic tick;
  } gen_t;

  gen_t q;
  gen_t d;
  logic edge_seen;
  logic [7:0] target;

  assign edge_seen = osc_i ^ q.osc;
  // Span reads one short on the realign cycle itself
  assign target = 8'((q.span + 10'h001) >> adc_pkg::SPAN_SHIFT);

  always_comb
  begin
    d = q;
    d.osc = osc_i;
    d.tick = 1'b0;
    if (!pll_en_i)
    begin
      d.tick = edge_seen;
    end
    else
    begin
      d.span = q.span + 10'h001;
      d.phase = q.phase + 8'h01;
      if (d.phase >= q.step)
      begin
        d.tick = 1'b1;
        d.phase = 8'h00;
      end
      if (edge_seen)
      begin
        d.trans = q.trans + 2'h1;
        if (q.trans == adc_pkg::REALIGN_TRANS)
        begin
          // Single step per realign keeps the frequency from jumping
          if (target > q.step)
          begin
            d.step = q.step + 8'h01;
          end
          else if (target < q.step && q.step > adc_pkg::STEP_MIN)
          begin
            d.step = q.step - 8'h01;
          end
          d.span = 10'h000;
          d.phase = 8'h00;
          d.tick = 1'b1;
        end
      end
    end
    if (d.tick)
    begin
      d.cpu_clk = ~q.cpu_clk;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      // Edge detector starts at the pin level, so no false tick follows reset
      q <= '{osc: osc_i, trans: 2'h0, span: 10'h000, step: adc_pkg::STEP_INIT,
             phase: 8'h00, cpu_clk: 1'b0, tick: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign cpu_clk_o = q.cpu_clk;
  assign tick_o = q.tick;

  chk_direct_follow: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (!pll_en_i && (osc_i != q.osc)) |=> tick_o)
    else $error("direct tick missing on oscillator edge");
  chk_step_gradual: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (q.step == $past(q.step)) || (q.step == $past(q.step) + 8'h01)
      || (q.step == $past(q.step) - 8'h01))
    else $error("loop step moved by more than one");
  chk_both_edges: assert property (
    @(posedge clock_i) disable iff (srst_i)
    tick_o |-> (cpu_clk_o != $past(cpu_clk_o)))
    else $error("tick without cpu clock edge");
endmodule
